// *** src/dcsw_top.sv ***
// Command word interpreter and drive sequencer for fieldbus control
//
// Contract
// - Ramp stop low: decelerate on active ramp, then ready to switch on.
// - Coast stop low: coast to stop, then switch-on inhibited.
// - Quick stop low: stop within set time, then switch-on inhibited.
// - Run set with run permissive advances to operation enabled.
// - Run cleared inhibits operation, back to operation inhibited.
// - Bit 4 low forces ramp output to zero; high enables it.
// - Bit 5 low freezes ramp output; high lets it ramp.
// - Bit 6 low forces ramp input to zero; high operates normally.
// - Bit 6 counts only when the fieldbus is its configured source.
// - Rising bit 7 during a fault clears it, then switch-on inhibited.
// - Bit 7 counts only when the fieldbus is the reset source.
// - Bit 10 enables fieldbus control; else only stop bits 0..2 count.
// - Bit 11 picks location B or A when configured from fieldbus.
// - State bits 0..2 report ready, ready to operate, operation enabled.
// - State bit 6 set while switch-on inhibited.
// - State bit 8 set while operation enabled and actual is within tolerance of reference.
// - State bit 9 set when control is remote.
// - State bit 10 mirrors bit 10 of the second internal status word.
// - State bits 11..14 each carry a configured internal signal.
`timescale 1ns/1ps
`default_nettype none
module dcsw_top #(
    parameter int QSTOP_CYCLES = dcsw_pkg::QSTOP_CYCLES
) (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic [15:0] cmdWord,
    input wire logic cmdUpdate,
    input wire logic cfgRunPermFromBus,
    input wire logic runPermissiveIn,
    input wire logic cfgRampInFromBus,
    input wire logic cfgResetFromBus,
    input wire logic cfgLocFromBus,
    input wire logic localLocBSelect,
    input wire logic localControl,
    input wire logic faultActive,
    input wire logic warningActive,
    input wire logic speedZero,
    input wire logic signed [15:0] actualValue,
    input wire logic signed [15:0] referenceValue,
    input wire logic [15:0] targetTolerance,
    input wire logic [15:0] driveStatusWord2,
    input wire logic [4*dcsw_pkg::USER_SEL_W-1:0] userSel,
    input wire logic [dcsw_pkg::INT_SIG_W-1:0] userSignals,
    output logic [15:0] statusWord,
    output logic modulatorOn,
    output logic rampOutZero,
    output logic rampHold,
    output logic rampInZero,
    output logic rampStopActive,
    output logic coastStopActive,
    output logic quickStopActive,
    output logic faultClear,
    output logic locBSelected,
    output logic [dcsw_pkg::USER_W-1:0] userCmdBits
);
    import dcsw_pkg::*;

    localparam int CNT_W = $clog2(QSTOP_CYCLES + 1);

    generate
        if (QSTOP_CYCLES < 1) begin : g_bad_qstop
            $error("QSTOP_CYCLES must be at least one");
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////////
    // Command capture
    logic [15:0] stopBits_q;
    logic [15:0] cmdAcc_q;
    logic busCtrl_q;
    logic resetPrev_q;
    logic [15:0] cmdAcc_d;
    logic acceptWord;
    logic resetEdge;

    // Stop bits are live whatever bit 10 says; everything else freezes
    // at its last accepted value while fieldbus control is withdrawn.
    assign acceptWord = cmdUpdate && cmdWord[CW_REMOTE];
    assign cmdAcc_d = acceptWord ? cmdWord : cmdAcc_q;

    // Edge is judged per cyclic update, so a bit held high across
    // updates never resets twice.
    assign resetEdge = cmdUpdate && cmdWord[CW_FAULT_RESET] && !resetPrev_q
                       && cmdWord[CW_REMOTE] && cfgResetFromBus;

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            stopBits_q <= CMD_RST;
            cmdAcc_q <= CMD_RST;
            busCtrl_q <= 1'b0;
            resetPrev_q <= 1'b0;
        end else begin
            if (cmdUpdate) begin
                stopBits_q <= cmdWord;
                busCtrl_q <= cmdWord[CW_REMOTE];
                resetPrev_q <= cmdWord[CW_FAULT_RESET];
            end
            cmdAcc_q <= cmdAcc_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Decoded command levels
    wire rampStopReq = !stopBits_q[CW_RAMP_STOP_N];
    wire coastStopReq = !stopBits_q[CW_COAST_STOP_N];
    wire quickStopReq = !stopBits_q[CW_QUICK_STOP_N];
    wire runCmd = cmdAcc_q[CW_RUN];
    wire runPermissive = cfgRunPermFromBus ? runCmd : runPermissiveIn;
    wire runOk = runCmd && runPermissive;
    wire rampOutEn = cmdAcc_q[CW_RAMP_OUT_EN];
    wire rampRunEn = cmdAcc_q[CW_RAMP_RUN];
    // When another source owns ramp input, this bit reads as "normal"
    wire rampInEn = cfgRampInFromBus ? cmdAcc_q[CW_RAMP_IN_EN] : 1'b1;
    wire locB = cfgLocFromBus ? cmdAcc_q[CW_LOC_B] : localLocBSelect;

    ////////////////////////////////////////////////////////////////////////////////
    // Quick stop timer
    logic [CNT_W-1:0] qsCnt_q;
    logic [CNT_W-1:0] qsCnt_d;
    logic qsExpired;
    dcsw_state_t state_q;
    dcsw_state_t state_d;

    assign qsExpired = (qsCnt_q == CNT_W'(QSTOP_CYCLES));
    assign qsCnt_d = (state_q != ST_QUICK_STOP) ? '0
                   : (qsExpired ? qsCnt_q : qsCnt_q + CNT_W'(1));

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            qsCnt_q <= '0;
        end else begin
            qsCnt_q <= qsCnt_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Sequencer
    // A fault outranks every stop; coast outranks quick, quick outranks
    // ramp stop, matching how hard each one takes torque away.
    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_SWON_INHIBIT: begin
                if (rampStopReq && !coastStopReq && !quickStopReq) begin
                    state_d = ST_READY_SWON;
                end
            end
            ST_READY_SWON: begin
                if (coastStopReq || quickStopReq) begin
                    state_d = ST_SWON_INHIBIT;
                end else if (!rampStopReq) begin
                    state_d = ST_READY_OP;
                end
            end
            ST_READY_OP: begin
                if (coastStopReq || quickStopReq) begin
                    state_d = ST_SWON_INHIBIT;
                end else if (rampStopReq) begin
                    state_d = ST_READY_SWON;
                end else if (runOk) begin
                    state_d = ST_OP_ENABLED;
                end
            end
            ST_OP_ENABLED: begin
                if (coastStopReq) begin
                    state_d = ST_COAST_STOP;
                end else if (quickStopReq) begin
                    state_d = ST_QUICK_STOP;
                end else if (rampStopReq) begin
                    state_d = ST_RAMP_STOP;
                end else if (!runOk) begin
                    state_d = ST_READY_OP;
                end
            end
            ST_RAMP_STOP: begin
                if (coastStopReq) begin
                    state_d = ST_COAST_STOP;
                end else if (quickStopReq) begin
                    state_d = ST_QUICK_STOP;
                end else if (speedZero) begin
                    state_d = ST_READY_SWON;
                end
            end
            ST_COAST_STOP: begin
                if (speedZero) begin
                    state_d = ST_SWON_INHIBIT;
                end
            end
            ST_QUICK_STOP: begin
                if (coastStopReq) begin
                    state_d = ST_COAST_STOP;
                end else if (speedZero || qsExpired) begin
                    state_d = ST_SWON_INHIBIT;
                end
            end
            ST_FAULT: begin
                if (resetEdge) begin
                    state_d = ST_SWON_INHIBIT;
                end
            end
            default: begin
                state_d = ST_SWON_INHIBIT;
            end
        endcase
        // A fault that is still present after a reset re-enters FAULT
        if (faultActive && !(state_q == ST_FAULT && resetEdge)) begin
            state_d = ST_FAULT;
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            state_q <= ST_SWON_INHIBIT;
        end else begin
            state_q <= state_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Drive-side outputs
    logic [16:0] diff;
    logic [16:0] absDiff;
    logic onTarget_d;
    logic onTarget_q;
    logic opNow;
    logic running;

    assign opNow = (state_d == ST_OP_ENABLED);
    assign running = opNow || (state_d == ST_RAMP_STOP) || (state_d == ST_QUICK_STOP);

    // Difference is taken one bit wider so full-scale opposite signs
    // cannot wrap into a false match.
    assign diff = 17'(signed'({actualValue[15], actualValue})
                      - signed'({referenceValue[15], referenceValue}));
    assign absDiff = diff[16] ? 17'(-signed'(diff)) : diff;
    assign onTarget_d = (absDiff <= {1'b0, targetTolerance});

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            modulatorOn <= 1'b0;
            rampOutZero <= 1'b1;
            rampHold <= 1'b1;
            rampInZero <= 1'b1;
            rampStopActive <= 1'b0;
            coastStopActive <= 1'b0;
            quickStopActive <= 1'b0;
            faultClear <= 1'b0;
            locBSelected <= 1'b0;
            userCmdBits <= '0;
            onTarget_q <= 1'b0;
        end else begin
            modulatorOn <= running;
            rampOutZero <= !(opNow && rampOutEn);
            rampHold <= !rampRunEn;
            rampInZero <= !(opNow && rampInEn);
            rampStopActive <= (state_d == ST_RAMP_STOP);
            coastStopActive <= (state_d == ST_COAST_STOP);
            quickStopActive <= (state_d == ST_QUICK_STOP);
            faultClear <= (state_q == ST_FAULT) && resetEdge;
            locBSelected <= locB;
            // Bits 8 and 9 have no consumer at all
            userCmdBits <= cmdAcc_q[CW_USER_LO +: USER_W];
            onTarget_q <= onTarget_d && (state_q == ST_OP_ENABLED);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // State word
    dcsw_stat_if stat();

    assign stat.readySwOn = (state_q == ST_READY_SWON) || (state_q == ST_READY_OP)
                            || (state_q == ST_OP_ENABLED);
    assign stat.readyOp = (state_q == ST_READY_OP) || (state_q == ST_OP_ENABLED);
    assign stat.opEnabled = (state_q == ST_OP_ENABLED);
    assign stat.faulted = (state_q == ST_FAULT);
    assign stat.coastInactive = !coastStopReq && (state_q != ST_COAST_STOP);
    assign stat.quickInactive = !quickStopReq && (state_q != ST_QUICK_STOP);
    assign stat.swOnInhibited = (state_q == ST_SWON_INHIBIT);
    assign stat.warning = warningActive;
    assign stat.onTarget = onTarget_q;
    assign stat.remote = !localControl;
    assign stat.aboveLimit = driveStatusWord2[DSW2_ABOVE_LIMIT];

    dcsw_status_word u_status (
        .core_clk(core_clk),
        .resetn(resetn),
        .st(stat),
        .userSel(userSel),
        .userSignals(userSignals),
        .statusWord(statusWord)
    );

    // Fieldbus control flag is registered but nothing reads it; the state word takes remote from localControl
    logic unusedBusCtrl;
    assign unusedBusCtrl = busCtrl_q;
endmodule
`default_nettype wire

// *** src/dcsw_pkg.sv ***
// Constants, state encoding and helpers for the drive command and state word logic
package dcsw_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // Command word bit positions
    localparam int CW_RAMP_STOP_N = 0;
    localparam int CW_COAST_STOP_N = 1;
    localparam int CW_QUICK_STOP_N = 2;
    localparam int CW_RUN = 3;
    localparam int CW_RAMP_OUT_EN = 4;
    localparam int CW_RAMP_RUN = 5;
    localparam int CW_RAMP_IN_EN = 6;
    localparam int CW_FAULT_RESET = 7;
    localparam int CW_REMOTE = 10;
    localparam int CW_LOC_B = 11;
    localparam int CW_USER_LO = 12;
    localparam int USER_W = 4;

    ////////////////////////////////////////////////////////////////////////////////
    // State word bit positions
    localparam int SW_READY_SWON = 0;
    localparam int SW_READY_OP = 1;
    localparam int SW_OP_ENABLED = 2;
    localparam int SW_FAULT = 3;
    localparam int SW_COAST_OFF = 4;
    localparam int SW_QUICK_OFF = 5;
    localparam int SW_SWON_INHIBIT = 6;
    localparam int SW_WARNING = 7;
    localparam int SW_ON_TARGET = 8;
    localparam int SW_REMOTE = 9;
    localparam int SW_ABOVE_LIMIT = 10;
    localparam int SW_USER_LO = 11;
    localparam int DSW2_ABOVE_LIMIT = 10;

    ////////////////////////////////////////////////////////////////////////////////
    // Reset values, widths and timing
    localparam logic [15:0] CMD_RST = 16'h0000;
    localparam logic [15:0] STAT_RST = 16'h0000;
    localparam int USER_SEL_W = 3;
    localparam int INT_SIG_W = 8;
    localparam int CLK_FREQ_HZ = 40000000;
    localparam int QSTOP_TIME_US = 1000;
    localparam int QSTOP_CYCLES = QSTOP_TIME_US * (CLK_FREQ_HZ / 1000000);

    typedef enum logic [7:0] {
        ST_SWON_INHIBIT = 8'h01,
        ST_READY_SWON = 8'h02,
        ST_READY_OP = 8'h04,
        ST_OP_ENABLED = 8'h08,
        ST_RAMP_STOP = 8'h10,
        ST_COAST_STOP = 8'h20,
        ST_QUICK_STOP = 8'h40,
        ST_FAULT = 8'h80
    } dcsw_state_t;

    // Picks one internal signal for a user state bit
    function automatic logic user_pick(input logic [USER_SEL_W-1:0] sel,
                                       input logic [INT_SIG_W-1:0] vec);
        user_pick = vec[sel];
    endfunction

endpackage

// *** src/dcsw_stat_if.sv ***
// Flags carried from the sequencer to the state word assembler
`timescale 1ns/1ps
`default_nettype none
interface dcsw_stat_if;
    logic readySwOn;
    logic readyOp;
    logic opEnabled;
    logic faulted;
    logic coastInactive;
    logic quickInactive;
    logic swOnInhibited;
    logic warning;
    logic onTarget;
    logic remote;
    logic aboveLimit;
    modport src(output readySwOn, readyOp, opEnabled, faulted, coastInactive, quickInactive,
                swOnInhibited, warning, onTarget, remote, aboveLimit);
    modport snk(input readySwOn, readyOp, opEnabled, faulted, coastInactive, quickInactive,
                swOnInhibited, warning, onTarget, remote, aboveLimit);
endinterface
`default_nettype wire

// *** src/dcsw_status_word.sv ***
// Assembles the registered 16-bit drive state word
`timescale 1ns/1ps
`default_nettype none
module dcsw_status_word (
    input wire logic core_clk,
    input wire logic resetn,
    dcsw_stat_if.snk st,
    input wire logic [4*dcsw_pkg::USER_SEL_W-1:0] userSel,
    input wire logic [dcsw_pkg::INT_SIG_W-1:0] userSignals,
    output logic [15:0] statusWord
);
    import dcsw_pkg::*;

    logic [USER_W-1:0] userBits;
    logic [15:0] status_d;

    ////////////////////////////////////////////////////////////////////////////////
    // User bits, each with its own selector
    genvar gi;
    generate
        for (gi = 0; gi < USER_W; gi++) begin : g_user
            assign userBits[gi] = user_pick(userSel[gi*USER_SEL_W +: USER_SEL_W],
                                            userSignals);
        end
    endgenerate

    assign status_d[SW_READY_SWON] = st.readySwOn;
    assign status_d[SW_READY_OP] = st.readyOp;
    assign status_d[SW_OP_ENABLED] = st.opEnabled;
    assign status_d[SW_FAULT] = st.faulted;
    assign status_d[SW_COAST_OFF] = st.coastInactive;
    assign status_d[SW_QUICK_OFF] = st.quickInactive;
    assign status_d[SW_SWON_INHIBIT] = st.swOnInhibited;
    assign status_d[SW_WARNING] = st.warning;
    assign status_d[SW_ON_TARGET] = st.onTarget;
    assign status_d[SW_REMOTE] = st.remote;
    assign status_d[SW_ABOVE_LIMIT] = st.aboveLimit;
    assign status_d[SW_USER_LO +: USER_W] = userBits;
    assign status_d[15] = 1'b0;

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            statusWord <= STAT_RST;
        end else begin
            statusWord <= status_d;
        end
    end
endmodule
`default_nettype wire

// *** tb/dcsw_master_model.sv ***
// Bus master model that delivers cyclic command word updates
`timescale 1ns/1ps
`default_nettype none
module dcsw_master_model (
    input wire logic core_clk,
    output logic [15:0] cmdWord,
    output logic cmdUpdate
);
    initial begin
        cmdWord = 16'h0000;
        cmdUpdate = 1'b0;
    end

    // Word and strobe launched after an edge and held through the taking edge
    task automatic send(input logic [15:0] w);
        @(posedge core_clk);
        cmdWord <= w;
        cmdUpdate <= 1'b1;
        @(posedge core_clk);
        cmdUpdate <= 1'b0;
    endtask

    // A low word always goes first, otherwise no rising edge is seen
    task automatic pulseReset(input logic [15:0] w);
        send(w & 16'hff7f);
        send(w | 16'h0080);
    endtask
endmodule
`default_nettype wire

// *** tb/dcsw_top_properties.sv ***
// Concurrent checks on the ports of the command and state word logic
`timescale 1ns/1ps
`default_nettype none
module dcsw_top_properties #(
    parameter int QSTOP_CYCLES = 8
) (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic [15:0] cmdWord,
    input wire logic cmdUpdate,
    input wire logic localControl,
    input wire logic faultActive,
    input wire logic warningActive,
    input wire logic [15:0] driveStatusWord2,
    input wire logic [15:0] statusWord,
    input wire logic modulatorOn,
    input wire logic rampOutZero,
    input wire logic rampInZero,
    input wire logic quickStopActive,
    input wire logic faultClear,
    input wire logic [dcsw_pkg::USER_W-1:0] userCmdBits
);
    import dcsw_pkg::*;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);

    wire logic acceptNow = cmdUpdate && cmdWord[CW_REMOTE];
    logic [15:0] quickCnt_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Length of a quick stop run, bounded by the stop time even at standstill miss
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            quickCnt_q <= 16'h0000;
        end else begin
            quickCnt_q <= quickStopActive ? quickCnt_q + 16'h0001 : 16'h0000;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    reserved_zero_a: assert property (statusWord[15] == 1'b0)
        else $error("reserved state bit set");
    warning_flag_a: assert property ($stable(warningActive) [*3] |->
        statusWord[SW_WARNING] == warningActive) else $error("warning bit wrong");
    remote_flag_a: assert property ($stable(localControl) [*3] |->
        statusWord[SW_REMOTE] == !localControl) else $error("remote bit wrong");
    above_limit_a: assert property ($stable(driveStatusWord2) [*3] |->
        statusWord[SW_ABOVE_LIMIT] == driveStatusWord2[DSW2_ABOVE_LIMIT])
        else $error("above limit bit wrong");
    clear_pulse_a: assert property (faultClear |=> !faultClear)
        else $error("fault clear longer than one cycle");
    fault_shown_a: assert property ((faultActive && !cmdUpdate) [*5] |=>
        statusWord[SW_FAULT]) else $error("fault not shown");
    inhibit_excl_a: assert property (statusWord[SW_SWON_INHIBIT] |->
        !statusWord[SW_OP_ENABLED] && !statusWord[SW_READY_SWON])
        else $error("inhibited together with ready");
    ramp_idle_a: assert property (!modulatorOn |-> rampOutZero && rampInZero)
        else $error("ramp released while modulator off");
    quick_bound_a: assert property (quickCnt_q <= QSTOP_CYCLES + 3)
        else $error("quick stop outlasts its time");
    user_hold_a: assert property ($changed(userCmdBits) |-> $past(acceptNow) ||
        $past(acceptNow, 2) || $past(acceptNow, 3)) else $error("user bits moved unasked");

    cover property (faultClear);
    cover property (quickStopActive [*3]);
    cover property (statusWord[SW_OP_ENABLED] && statusWord[SW_ON_TARGET]);
endmodule

bind dcsw_top dcsw_top_properties #(.QSTOP_CYCLES(QSTOP_CYCLES)) dcsw_top_properties_inst (
    .core_clk, .resetn, .cmdWord, .cmdUpdate, .localControl, .faultActive, .warningActive,
    .driveStatusWord2, .statusWord, .modulatorOn, .rampOutZero, .rampInZero,
    .quickStopActive, .faultClear, .userCmdBits);
`default_nettype wire

// *** tb/dcsw_top_test.sv ***
// Self-checking bench for the command and state word logic
`timescale 1ns/1ps
`default_nettype none
module dcsw_top_test;
    import dcsw_pkg::*;
    localparam int QS = 8;
    logic core_clk = 1'b0;
    logic resetn = 1'b0;
    logic [15:0] cmdWord;
    logic cmdUpdate;
    logic cfgRunPermFromBus = 1'b1, runPermissiveIn = 1'b0, cfgRampInFromBus = 1'b1;
    logic cfgResetFromBus = 1'b1, cfgLocFromBus = 1'b1, localLocBSelect = 1'b0;
    logic localControl = 1'b0, faultActive = 1'b0, warningActive = 1'b0, speedZero = 1'b0;
    logic signed [15:0] actualValue = 16'sh0064, referenceValue = 16'sh006e;
    logic [15:0] targetTolerance = 16'h0014, driveStatusWord2 = 16'h0000;
    logic [4*USER_SEL_W-1:0] userSel = '0;
    logic [INT_SIG_W-1:0] userSignals = '0;
    logic [15:0] statusWord;
    logic modulatorOn, rampOutZero, rampHold, rampInZero, rampStopActive, coastStopActive;
    logic quickStopActive, faultClear, locBSelected;
    logic [USER_W-1:0] userCmdBits;
    logic [15:0] rampWords[3] = '{16'h046f, 16'h045f, 16'h043f};
    int corner[4] = '{20, -20, 21, -21};
    int mismatches = 0, nCompared = 0, clears = 0, d, r;

    dcsw_top #(.QSTOP_CYCLES(QS)) dcsw_top_inst (.core_clk, .resetn, .cmdWord, .cmdUpdate,
        .cfgRunPermFromBus, .runPermissiveIn, .cfgRampInFromBus, .cfgResetFromBus,
        .cfgLocFromBus, .localLocBSelect, .localControl, .faultActive, .warningActive,
        .speedZero, .actualValue, .referenceValue, .targetTolerance, .driveStatusWord2,
        .userSel, .userSignals, .statusWord, .modulatorOn, .rampOutZero, .rampHold,
        .rampInZero, .rampStopActive, .coastStopActive, .quickStopActive, .faultClear,
        .locBSelected, .userCmdBits);
    dcsw_master_model dcsw_master_model_inst (.core_clk, .cmdWord, .cmdUpdate);

    initial begin
        forever #12.5 core_clk = ~core_clk;
    end

    always @(posedge core_clk) begin
        if (faultClear === 1'b1) clears++;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // State bits come from the argument, the rest from the live inputs
    function automatic logic [15:0] expSw(input logic [8:0] st);
        logic [3:0] u;
        for (int i = 0; i < 4; i++) u[i] = userSignals[userSel[i*USER_SEL_W +: USER_SEL_W]];
        return {1'b0, u, driveStatusWord2[DSW2_ABOVE_LIMIT], !localControl, st[8],
                warningActive, st[6:0]};
    endfunction

    function automatic logic onTargetExp();
        int e;
        e = int'(actualValue) - int'(referenceValue);
        return (e < 0 ? -e : e) <= int'(targetTolerance);
    endfunction

    task automatic cmpW(input logic [15:0] got, input logic [15:0] exp);
        nCompared++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic cmpB(input logic got, input logic exp);
        cmpW({15'h0000, got}, {15'h0000, exp});
    endtask

    // Sample a little after the edge so that its updates have landed
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    task automatic go(input logic [15:0] w, input logic [8:0] st);
        dcsw_master_model_inst.send(w);
        tick(6);
        cmpW(statusWord, expSw(st));
    endtask

    task automatic giveVerdict();
        $display("compared %0d mismatches %0d", nCompared, mismatches);
        if (mismatches == 0 && nCompared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    initial begin
        #500000;
        mismatches++;
        giveVerdict();
    end

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(32'ha73f_37b9));
        repeat (16) @(posedge core_clk);
        resetn <= 1'b1;
        tick(2);
        cmpW(statusWord, expSw(9'h040));
        go(16'h0406, 9'h031);
        go(16'h047f, 9'h137);
        cmpW(16'({modulatorOn, rampOutZero, rampHold, rampInZero}), 16'h0008);
        for (int i = 0; i < 3; i++) begin
            dcsw_master_model_inst.send(rampWords[i]);
            tick(4);
            cmpW(16'({rampOutZero, rampHold, rampInZero}), 16'(3'b100 >> i));
        end
        @(posedge core_clk);
        cfgRampInFromBus <= 1'b0;
        tick(4);
        cmpB(rampInZero, 1'b0);
        cfgRampInFromBus <= 1'b1;
        go(16'h047f, 9'h137);
        for (int i = 0; i < 12; i++) begin
            @(posedge core_clk);
            d = i < 4 ? corner[i] : int'($urandom_range(80)) - 40;
            r = int'($urandom_range(2000));
            referenceValue <= 16'(r);
            actualValue <= 16'(r + d);
            warningActive <= 1'($urandom);
            localControl <= 1'($urandom);
            driveStatusWord2 <= 16'($urandom);
            userSel <= 12'($urandom);
            userSignals <= 8'($urandom);
            tick(5);
            cmpW(statusWord, expSw({onTargetExp(), 8'h37}));
        end
        @(posedge core_clk);
        actualValue <= referenceValue;
        go(16'h0077, 9'h137);
        go(16'h0477, 9'h033);
        go(16'h0c7f, 9'h137);
        cmpB(locBSelected, 1'b1);
        go(16'h037f, 9'h137);
        cmpB(locBSelected, 1'b1);
        @(posedge core_clk);
        cfgLocFromBus <= 1'b0;
        tick(4);
        cmpB(locBSelected, 1'b0);
        r = $urandom;
        go({r[3:0], 2'b01, r[5:4], 8'h7f}, 9'h137);
        cmpW(16'(userCmdBits), 16'(r[3:0]));
        dcsw_master_model_inst.send(16'h047e);
        tick(3);
        cmpB(rampStopActive, 1'b1);
        @(posedge core_clk);
        speedZero <= 1'b1;
        tick(6);
        cmpW(statusWord, expSw(9'h031));
        speedZero <= 1'b0;
        go(16'h047f, 9'h137);
        dcsw_master_model_inst.send(16'h047d);
        tick(3);
        cmpB(coastStopActive, 1'b1);
        @(posedge core_clk);
        speedZero <= 1'b1;
        tick(6);
        cmpW(statusWord, expSw(9'h060));
        speedZero <= 1'b0;
        go(16'h0406, 9'h031);
        go(16'h047f, 9'h137);
        dcsw_master_model_inst.send(16'h047b);
        tick(3);
        cmpB(quickStopActive, 1'b1);
        tick(QS + 6);
        cmpW(statusWord, expSw(9'h050));
        go(16'h0406, 9'h031);
        // Permissive from its own pin: run alone must not reach operation
        @(posedge core_clk);
        cfgRunPermFromBus <= 1'b0;
        go(16'h047f, 9'h033);
        @(posedge core_clk);
        runPermissiveIn <= 1'b1;
        tick(6);
        cmpW(statusWord, expSw(9'h137));
        @(posedge core_clk);
        faultActive <= 1'b1;
        cfgResetFromBus <= 1'b0;
        tick(6);
        cmpB(statusWord[SW_FAULT], 1'b1);
        faultActive <= 1'b0;
        dcsw_master_model_inst.pulseReset(16'h0407);
        tick(6);
        cmpB(statusWord[SW_FAULT], 1'b1);
        cfgResetFromBus <= 1'b1;
        dcsw_master_model_inst.pulseReset(16'h0407);
        tick(6);
        cmpW(statusWord, expSw(9'h070));
        cmpW(16'(clears), 16'h0001);
        giveVerdict();
    end
endmodule
`default_nettype wire
